// ==== pkg/psram_cfg_defines.svh ====
// Offsets, field positions, reset values and constants of the mode block
// Contract
// - Write-mode bit: cleared gives burst write, set gives single write.
// - Strobe bit cleared: single-clock strobe control, no burst suspend.
// - Single-clock control: strobe read at first edge with address low.
// - Strobe bit set: level control with burst suspend and resume.
// - Page-return bit cleared enables return to page mode; set disables.
// - Function bit: cleared burst, set page; page mode after reset.
// - Latency codes 010..111 give five to ten; write latency one less.
// - Top address read twice in a row blocks sequence entry.
// - Burst-length codes give 8, 16 or continuous; others reserved.
`ifndef PSRAM_CFG_DEFINES_SVH
`define PSRAM_CFG_DEFINES_SVH

`define MEM_AW       23
`define MEM_DW       16
`define TOP_ADDR     23'h7fffff
`define AXI_AW       8

`define W1_RST       16'hffff
`define W2_RST       16'hff62
`define W1_RSV_MASK  16'hff80
`define W2_RSV_MASK  16'hff60
`define W1_LENC      4:2
`define W1_MODE      5
`define W1_VE        6
`define W2_LATC      2:0
`define W2_SGL       3
`define W2_LVL       4
`define W2_NORET     7

`define LEN_8        3'h2
`define LEN_16       3'h3
`define LEN_CONT     3'h7
`define WORDS_8      5'h08
`define WORDS_16     5'h10
`define LATC_MIN     3'h2
`define LATC_OFS     4'h3

`define OFS_CTRL     8'h00
`define OFS_CFG1     8'h04
`define OFS_CFG2     8'h08
`define OFS_STATUS   8'h0c
`define CTRL_EN      0
`define CTRL_CLR     1
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// ==== pkg/psram_cfg_pkg.sv ====
// Types of the mode block
package psram_cfg_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_WR1, SEQ_WR2, SEQ_DATA1, SEQ_DATA2, SEQ_FINAL
    } seq_state_t;
    typedef enum logic [2:0] {
        BW_IDLE, BW_READ, BW_LAT, BW_DATA, BW_HOLD
    } bw_state_t;
endpackage : psram_cfg_pkg

// ==== pkg/bus_event_if.sv ====
// Memory bus events passed from the pin sampler to the decoder
`timescale 1ns/1ns
interface bus_event_if #(
    parameter int AW = 23,
    parameter int DW = 16
);
    logic          wr_evt;
    logic          rd_evt;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic          clk_rise;
    logic          clk_fall;
    logic          adv_low;
    logic          ce_low;
    logic          we_low;
    logic          stby_rise;
    modport src (output wr_evt, rd_evt, addr, data, clk_rise, clk_fall,
                 adv_low, ce_low, we_low, stby_rise);
    modport dst (input wr_evt, rd_evt, addr, data, clk_rise, clk_fall,
                 adv_low, ce_low, we_low, stby_rise);
endinterface : bus_event_if

// ==== verilog/bus_cycle_sampler.sv ====
// Pin synchroniser and bus cycle event detector
`timescale 1ns/1ns
module bus_cycle_sampler #(
    parameter int AW = 23,
    parameter int DW = 16
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          mem_ce_n,
    input  wire logic          mem_oe_n,
    input  wire logic          mem_we_n,
    input  wire logic          addr_valid_strobe_n,
    input  wire logic          mem_clk,
    input  wire logic          standby_mode_input,
    input  wire logic [AW-1:0] mem_addr,
    input  wire logic [DW-1:0] mem_dq,
    bus_event_if.src           ev
);
    localparam int VW     = AW + DW + 6;
    localparam int P_STBY = AW + DW;
    localparam int P_CLK  = AW + DW + 1;
    localparam int P_ADV  = AW + DW + 2;
    localparam int P_WE   = AW + DW + 3;
    localparam int P_OE   = AW + DW + 4;
    localparam int P_CE   = AW + DW + 5;
    // Memory clock idles low outside bursts, every other pin high
    localparam logic [VW-1:0] IDLE = ~(VW'(1) << P_CLK);

    logic [VW-1:0] s1;
    logic [VW-1:0] s2;
    logic [VW-1:0] s3;
    logic [VW-1:0] next_s1;
    logic [VW-1:0] next_s2;
    logic [VW-1:0] next_s3;

    ////////////////////////////////////////////////////////////////////////
    // Two stages before use; third stage only feeds edge detection
    always_comb begin
        next_s1 = {mem_ce_n, mem_oe_n, mem_we_n, addr_valid_strobe_n,
                   mem_clk, standby_mode_input, mem_addr, mem_dq};
        next_s2 = s1;
        next_s3 = s2;
    end

    // Idle pin levels at reset so no false edge appears after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= IDLE;
            s2 <= IDLE;
            s3 <= IDLE;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and data are settled across the strobe edge, so the bus
    // vector is taken with its strobes without a further handshake
    assign ev.data      = s2[DW-1:0];
    assign ev.addr      = s2[AW+DW-1:DW];
    assign ev.stby_rise = s2[P_STBY] & ~s3[P_STBY];
    assign ev.clk_rise  = s2[P_CLK] & ~s3[P_CLK];
    assign ev.clk_fall  = ~s2[P_CLK] & s3[P_CLK];
    assign ev.adv_low   = ~s2[P_ADV];
    assign ev.we_low    = ~s2[P_WE];
    assign ev.ce_low    = ~s2[P_CE];
    assign ev.wr_evt    = s2[P_WE] & ~s3[P_WE] & ~s2[P_CE];
    assign ev.rd_evt    = ~s2[P_OE] & s3[P_OE] & ~s2[P_CE];
endmodule : bus_cycle_sampler

// ==== verilog/psram_mode_config_second_word.sv ====
// Mode sequence decoder, burst write control and AXI4-Lite registers
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`include "psram_cfg_defines.svh"
module psram_mode_config_second_word (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [`AXI_AW-1:0] awaddr,
    input  wire logic [2:0]         awprot,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [`AXI_AW-1:0] araddr,
    input  wire logic [2:0]         arprot,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire logic               mem_ce_n,
    input  wire logic               mem_oe_n,
    input  wire logic               mem_we_n,
    input  wire logic               addr_valid_strobe_n,
    input  wire logic               mem_clk,
    input  wire logic               standby_mode_input,
    input  wire logic [`MEM_AW-1:0] mem_addr,
    input  wire logic [`MEM_DW-1:0] mem_dq,
    output logic                    page_mode,
    output logic                    burst_write_busy,
    output logic                    write_beat,
    output logic                    write_suspended
);
    bus_event_if #(.AW(`MEM_AW), .DW(`MEM_DW)) ev ();

    bus_cycle_sampler #(.AW(`MEM_AW), .DW(`MEM_DW)) u_sampler (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .mem_ce_n            (mem_ce_n),
        .mem_oe_n            (mem_oe_n),
        .mem_we_n            (mem_we_n),
        .addr_valid_strobe_n (addr_valid_strobe_n),
        .mem_clk             (mem_clk),
        .standby_mode_input  (standby_mode_input),
        .mem_addr            (mem_addr),
        .mem_dq              (mem_dq),
        .ev                  (ev)
    );

    function automatic logic [3:0] lat_clocks(input logic [2:0] code);
        lat_clocks = {1'b0, code} + `LATC_OFS;
    endfunction : lat_clocks

    function automatic logic [4:0] burst_len(input logic [2:0] code);
        case (code)
            `LEN_8:  burst_len = `WORDS_8;
            `LEN_16: burst_len = `WORDS_16;
            default: burst_len = 5'h00;
        endcase
    endfunction : burst_len

    ////////////////////////////////////////////////////////////////////////
    // Mode setting sequence
    psram_cfg_pkg::seq_state_t seq, next_seq;
    logic [15:0] d1, d2, next_d1, next_d2;
    logic [15:0] cfg1, cfg2, next_cfg1, next_cfg2;
    logic        top_run, next_top_run;
    logic        next_page;
    logic        ctrl_en, next_ctrl_en;
    logic        res_err, next_res_err;
    logic        seq_abort, next_seq_abort;
    logic        top_hit, commit, bad_rsv, abort, ctl_clr, ctl_wr, ctl_set;
    logic [3:0]  rd_lat, wr_lat;

    assign top_hit = ev.addr == `TOP_ADDR;
    assign rd_lat  = lat_clocks(cfg2[`W2_LATC]);
    assign wr_lat  = rd_lat - 4'h1;

    always_comb begin
        next_seq     = seq;
        next_d1      = d1;
        next_d2      = d2;
        next_top_run = top_run;
        commit       = 1'b0;
        bad_rsv      = 1'b0;
        abort        = 1'b0;
        if (ev.rd_evt)
            next_top_run = top_hit;
        else if (ev.wr_evt)
            next_top_run = 1'b0;
        if (!ctrl_en) begin
            next_seq = psram_cfg_pkg::SEQ_IDLE;
        end else if (ev.rd_evt || ev.wr_evt) begin
            case (seq)
                psram_cfg_pkg::SEQ_IDLE: begin
                    // Repeated top reads do not open a sequence
                    if (ev.rd_evt && top_hit && !top_run)
                        next_seq = psram_cfg_pkg::SEQ_WR1;
                end
                psram_cfg_pkg::SEQ_WR1, psram_cfg_pkg::SEQ_WR2,
                psram_cfg_pkg::SEQ_DATA1, psram_cfg_pkg::SEQ_DATA2: begin
                    if (ev.wr_evt && top_hit) begin
                        next_seq = psram_cfg_pkg::seq_state_t'(seq + 3'h1);
                        if (seq == psram_cfg_pkg::SEQ_DATA1)
                            next_d1 = ev.data;
                        if (seq == psram_cfg_pkg::SEQ_DATA2)
                            next_d2 = ev.data;
                    end else begin
                        abort = 1'b1;
                    end
                end
                psram_cfg_pkg::SEQ_FINAL: begin
                    // Reserved bits not all one would reach test modes
                    bad_rsv =
                        ((d1 & `W1_RSV_MASK) != `W1_RSV_MASK) ||
                        ((d2 & `W2_RSV_MASK) != `W2_RSV_MASK);
                    if (!(ev.rd_evt && top_hit))
                        abort = 1'b1;
                    else if (!bad_rsv)
                        commit = 1'b1;
                end
                default: abort = 1'b1;
            endcase
            if (abort || seq == psram_cfg_pkg::SEQ_FINAL)
                next_seq = psram_cfg_pkg::SEQ_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration, mode and status flags
    always_comb begin
        next_cfg1      = cfg1;
        next_cfg2      = cfg2;
        next_page      = page_mode;
        next_ctrl_en   = ctrl_en;
        if (commit) begin
            next_cfg1 = d1;
            next_cfg2 = d2;
            next_page = d1[`W1_MODE];
        end
        // Standby toggle returns to page mode only when allowed
        if (ev.stby_rise && !page_mode && !cfg2[`W2_NORET])
            next_page = 1'b1;
        if (ctl_wr)
            next_ctrl_en = ctl_set;
        // Hardware set wins over a software clear in the same cycle
        next_res_err   = (res_err & ~ctl_clr) | bad_rsv;
        next_seq_abort = (seq_abort & ~ctl_clr) | abort;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq       <= psram_cfg_pkg::SEQ_IDLE;
            d1        <= `W1_RST;
            d2        <= `W2_RST;
            cfg1      <= `W1_RST;
            cfg2      <= `W2_RST;
            top_run   <= 1'b0;
            page_mode <= 1'b1;
            ctrl_en   <= 1'b1;
            res_err   <= 1'b0;
            seq_abort <= 1'b0;
        end else begin
            seq       <= next_seq;
            d1        <= next_d1;
            d2        <= next_d2;
            cfg1      <= next_cfg1;
            cfg2      <= next_cfg2;
            top_run   <= next_top_run;
            page_mode <= next_page;
            ctrl_en   <= next_ctrl_en;
            res_err   <= next_res_err;
            seq_abort <= next_seq_abort;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst write control on the selected memory clock edge
    psram_cfg_pkg::bw_state_t bw, next_bw;
    logic [3:0] lat, next_lat;
    logic [4:0] cnt, next_cnt, blen;
    logic       edge_ok, data_edge, next_beat, next_susp, next_busy;

    assign blen    = burst_len(cfg1[`W1_LENC]);
    assign edge_ok = !page_mode && ev.ce_low &&
                     (cfg1[`W1_VE] ? ev.clk_rise : ev.clk_fall);
    assign data_edge = edge_ok && (bw == psram_cfg_pkg::BW_DATA ||
                       (bw == psram_cfg_pkg::BW_LAT && lat == 4'h1));

    always_comb begin
        next_bw   = bw;
        next_lat  = lat;
        next_cnt  = cnt;
        next_beat = 1'b0;
        next_susp = write_suspended;
        if (!ev.ce_low) begin
            next_bw   = psram_cfg_pkg::BW_IDLE;
            next_susp = 1'b0;
        end else if (data_edge) begin
            next_bw = psram_cfg_pkg::BW_DATA;
            if (cfg2[`W2_LVL] && !ev.we_low) begin
                next_susp = 1'b1;
            end else begin
                next_susp = 1'b0;
                next_beat = 1'b1;
                next_cnt  = cnt + 5'h01;
                // Continuous bursts end only with chip enable
                if (cfg2[`W2_SGL] || (blen != 5'h00 && next_cnt == blen))
                    next_bw = psram_cfg_pkg::BW_HOLD;
            end
        end else if (edge_ok) begin
            case (bw)
                psram_cfg_pkg::BW_IDLE: begin
                    if (ev.adv_low) begin
                        next_cnt = 5'h00;
                        next_lat = wr_lat;
                        next_bw  = ev.we_low ? psram_cfg_pkg::BW_LAT
                                             : psram_cfg_pkg::BW_READ;
                    end
                end
                psram_cfg_pkg::BW_LAT: next_lat = lat - 4'h1;
                psram_cfg_pkg::BW_READ, psram_cfg_pkg::BW_HOLD,
                psram_cfg_pkg::BW_DATA: next_bw = bw;
                default: next_bw = psram_cfg_pkg::BW_IDLE;
            endcase
        end
        next_busy = next_bw == psram_cfg_pkg::BW_LAT ||
                    next_bw == psram_cfg_pkg::BW_DATA;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bw               <= psram_cfg_pkg::BW_IDLE;
            lat              <= 4'h0;
            cnt              <= 5'h00;
            write_beat       <= 1'b0;
            write_suspended  <= 1'b0;
            burst_write_busy <= 1'b0;
        end else begin
            bw               <= next_bw;
            lat              <= next_lat;
            cnt              <= next_cnt;
            write_beat       <= next_beat;
            write_suspended  <= next_susp;
            burst_write_busy <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one read in flight, a second write taken while a response waits
    logic [`AXI_AW-1:0] aw_addr, next_aw_addr;
    logic [31:0]        w_data, next_w_data, next_rdata, status;
    logic               aw_hold, w_hold, next_aw_hold, next_w_hold;
    logic               next_awready, next_wready, next_arready;
    logic               next_bvalid, next_rvalid, wr_go;
    logic [1:0]         next_bresp, next_rresp;
    logic               len_rsv, w_lane0, next_w_lane0;

    assign len_rsv = blen == 5'h00 && cfg1[`W1_LENC] != `LEN_CONT;
    assign status  = {16'h0, wr_lat, rd_lat, 1'b0, len_rsv,
                      cfg2[`W2_LATC] < `LATC_MIN, seq_abort, res_err,
                      write_suspended, burst_write_busy, page_mode};
    assign wr_go   = aw_hold && w_hold && !bvalid;
    // Strobe is kept with the data, the master may move it after the take
    assign ctl_wr  = wr_go && aw_addr == `OFS_CTRL && w_lane0;
    assign ctl_set = w_data[`CTRL_EN];
    assign ctl_clr = ctl_wr && w_data[`CTRL_CLR];

    always_comb begin
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_lane0 = w_lane0;
        next_aw_hold = aw_hold;
        next_w_hold  = w_hold;
        next_bvalid  = bvalid && !bready;
        next_bresp   = bresp;
        next_rvalid  = rvalid && !rready;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (awvalid && awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_hold = 1'b1;
            next_w_data = wdata;
            next_w_lane0 = wstrb[0];
        end
        if (wr_go) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = aw_addr == `OFS_CTRL ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            case (araddr)
                `OFS_CTRL:   next_rdata = {31'h0, ctrl_en};
                `OFS_CFG1:   next_rdata = {16'h0, cfg1};
                `OFS_CFG2:   next_rdata = {16'h0, cfg2};
                `OFS_STATUS: next_rdata = status;
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_hold;
        next_wready  = !next_w_hold;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= '0;
            w_data  <= 32'h0;
            w_lane0 <= 1'b0;
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            arready <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `RESP_OKAY;
        end else begin
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_lane0 <= next_w_lane0;
            aw_hold <= next_aw_hold;
            w_hold  <= next_w_hold;
            awready <= next_awready;
            wready  <= next_wready;
            arready <= next_arready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_read_start;
        bw == psram_cfg_pkg::BW_IDLE && edge_ok && !data_edge &&
        ev.adv_low && !ev.we_low;
    endsequence
    sequence s_write_start;
        bw == psram_cfg_pkg::BW_IDLE && edge_ok && !data_edge &&
        ev.adv_low && ev.we_low;
    endsequence

    a_commit_both: assert property (commit |=>
        cfg1 == $past(d1) && cfg2 == $past(d2))
        else $error("config words not committed together");
    a_cfg_hold: assert property (!commit |=> $stable(cfg2))
        else $error("second word changed outside commit");
    a_start_page: assert property ($rose(aresetn) |-> page_mode)
        else $error("not in page mode after reset");
    a_top_repeat: assert property (
        seq == psram_cfg_pkg::SEQ_IDLE && ctrl_en && ev.rd_evt &&
        top_hit && top_run |=> seq == psram_cfg_pkg::SEQ_IDLE)
        else $error("sequence entered after repeated top read");
    a_single_write: assert property (
        data_edge && cfg2[`W2_SGL] && !cfg2[`W2_LVL] |=>
        write_beat ##1 !write_beat [*2])
        else $error("single write gave more than one beat");
    a_no_suspend: assert property (
        data_edge && !cfg2[`W2_LVL] |=> write_beat && !write_suspended)
        else $error("suspend under single clock control");
    a_first_edge: assert property (s_read_start |=>
        bw == psram_cfg_pkg::BW_READ ##1 bw != psram_cfg_pkg::BW_LAT)
        else $error("strobe sampled after first edge");
    a_level_suspend: assert property (
        data_edge && cfg2[`W2_LVL] && !ev.we_low |=>
        write_suspended && !write_beat)
        else $error("level strobe high did not suspend");
    a_page_return: assert property (
        ev.stby_rise && !page_mode && !commit |=>
        page_mode == !$past(cfg2[`W2_NORET]))
        else $error("page return not as enabled");
    a_wl_load: assert property (s_write_start |=>
        lat == $past(rd_lat) - 4'h1)
        else $error("write latency not read latency minus one");
    a_b_answer: assert property (wr_go |=> bvalid && !aw_hold)
        else $error("write response missing");
endmodule : psram_mode_config_second_word

// ==== tb/mem_ctrl_model.sv ====
// Memory controller model driving mode and burst write bus cycles
`timescale 1ns/1ns
module mem_ctrl_model (
    input  wire logic   aclk,
    output logic        mem_ce_n = 1'b1,
    output logic        mem_oe_n = 1'b1,
    output logic        mem_we_n = 1'b1,
    output logic        addr_valid_strobe_n = 1'b1,
    output logic        mem_clk = 1'b0,
    output logic        standby_mode_input = 1'b1,
    output logic [22:0] mem_addr = 23'h0,
    output logic [15:0] mem_dq = 16'h0
);
    // Every level is held four aclk, the pin sampler needs three
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask : step
    task automatic acc(input logic wr, input logic [22:0] a,
                       input logic [15:0] d);
        mem_ce_n <= 1'b0; mem_addr <= a; mem_dq <= d; step(4);
        mem_we_n <= !wr; mem_oe_n <= wr; step(4);
        mem_we_n <= 1'b1; mem_oe_n <= 1'b1; step(4);
        // Released data lines flip so a stale value cannot pass
        mem_ce_n <= 1'b1; mem_dq <= ~d; step(4);
    endtask : acc
    task automatic mode_set(input logic [15:0] w1, w2);
        for (int k = 0; k < 6; k++)
            acc(k inside {[1:4]}, 23'h7fffff,
                k == 3 ? w1 : (k == 4 ? w2 : 16'hffff));
    endtask : mode_set
    // Clock runs only inside the frame, then standby pulses
    task automatic burst(input int n);
        mem_ce_n <= 1'b0; mem_we_n <= 1'b0; addr_valid_strobe_n <= 1'b0;
        step(4);
        mem_clk <= 1'b1; step(4);
        addr_valid_strobe_n <= 1'b1;
        // Strobe high over the eleventh rise: a suspend under level control
        for (int k = 0; k < 2 * n - 1; k++) begin
            mem_clk <= !mem_clk;
            if (k == 18 || k == 20)
                mem_we_n <= k == 18;
            step(4);
        end
        mem_we_n <= 1'b1; mem_ce_n <= 1'b1; step(4);
        standby_mode_input <= 1'b0; step(4);
        standby_mode_input <= 1'b1; step(8);
    endtask : burst
endmodule : mem_ctrl_model

// ==== tb/psram_mode_config_second_word_tb_top.sv ====
// Self-checking bench for the mode configuration block
`timescale 1ns/1ns
`include "psram_cfg_defines.svh"
module psram_mode_config_second_word_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic arvalid = 1'b0, bready = 1'b1, rready = 1'b1, awready, wready;
    logic bvalid, arready, rvalid, page_mode, burst_write_busy, write_beat;
    logic write_suspended, mem_ce_n, mem_oe_n, mem_we_n, mem_clk;
    logic addr_valid_strobe_n, standby_mode_input;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [2:0]  awprot = 3'h0, arprot = 3'h0, c;
    logic [3:0]  wstrb = 4'hf, r;
    logic [31:0] wdata = 32'h0, rdata, qd[$];
    logic [1:0]  bresp, rresp, seen, qr[$];
    logic [22:0] mem_addr;
    logic [15:0] mem_dq, w2;
    int          fail_count = 0, checked = 0, beats = 0;
    psram_mode_config_second_word uut (.*);
    mem_ctrl_model mdl (.*);
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) if (write_beat === 1'b1) beats++;
    always @(posedge aclk)
        seen |= {write_suspended === 1'b1, burst_write_busy === 1'b1};
    task automatic chk(input logic [31:0] s, e);
        checked++;
        if (s !== e) fail_count++;
        if (s !== e) $display("MISMATCH t=%0t saw %h want %h", $time, s, e);
    endtask : chk
    // Answers are matched in the order the requests went out
    always @(posedge aclk) begin
        if (rvalid && rready) chk(rdata, qd.pop_front());
        if (rvalid && rready) chk(32'(rresp), 32'(qr.pop_front()));
        if (bvalid && bready) chk(32'(bresp), 32'(qr.pop_front()));
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        qr.push_back(e);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (!bvalid) @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] p);
        qd.push_back(e);
        qr.push_back(p);
        araddr <= a; arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
    endtask : rd
    task automatic test_done();
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'h0cb0ca86));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(`OFS_STATUS, 32'h4501, `RESP_OKAY);
        rd(8'h10, 32'h0, `RESP_SLVERR);
        wr(`OFS_CFG1, 32'hffff, `RESP_SLVERR);
        mdl.mode_set(16'hffc8, 16'hfe6a);
        mdl.acc(1'b0, 23'h7fffff, 16'h0);
        mdl.mode_set(16'hffc8, 16'hff6a);
        rd(`OFS_CFG2, {16'h0, `W2_RST}, `RESP_OKAY);
        // The last top read opened a sequence; a stray write aborts it
        mdl.acc(1'b1, 23'h0, 16'h0);
        rd(`OFS_STATUS, 32'h4519, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h3, `RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            r = 4'($urandom);
            // Every pairing of strobe control and write mode once
            r[1:0] = 2'(i);
            c = 3'($urandom_range(7, 2));
            w2 = {8'hff, r[2], 2'b11, r[1:0], c};
            mdl.acc(1'b1, 23'h0, 16'h0);
            mdl.mode_set({12'hffc, 1'b1, r[3], 2'b00}, w2);
            rd(`OFS_CFG2, {16'h0, w2}, `RESP_OKAY);
            rd(`OFS_STATUS, {16'h0, 4'(c + 2), 4'(c + 3), 8'h0},
               `RESP_OKAY);
            beats = 0;
            seen = 2'b00;
            mdl.burst(28);
            chk(32'(beats), r[0] ? 1 : (r[3] ? 16 : 8));
            chk(32'(seen), {30'h0, r[1:0] == 2'b10, 1'b1});
            rd(`OFS_STATUS, {16'h0, 4'(c + 2), 4'(c + 3), 7'h0, !r[2]},
               `RESP_OKAY);
        end
        test_done();
    end
endmodule : psram_mode_config_second_word_tb_top
